/* design/bso_pkg.sv */
// bso_pkg: constants, types and cell-index helpers for the boundary-scan
// output-enable block.
// assumes: shared by the design file and the bench; nothing is imported.
package bso_pkg;

   // chain and lane sizes
   localparam int BSR_LEN   = 77;
   localparam int DATA_W    = 32;
   localparam int MISC_W    = 9;
   localparam int IR_W      = 4;
   localparam int SPLIT_LN  = 18;   // first data lane placed after the data enable cell

   // chain indices (cell number minus one, index 0 nearest tdi)
   localparam logic [6:0] NEN_DATA_IDX  = 7'h24;   // cell 37
   localparam logic [6:0] NEN_HS_IDX    = 7'h41;   // cell 66
   localparam logic [6:0] HS_B_IDX      = 7'h42;   // cell 67
   localparam logic [6:0] HS_A_IDX      = 7'h43;   // cell 68
   localparam logic [6:0] MISC_BASE_IDX = 7'h44;   // cells 69..77
   localparam logic [6:0] TDO_IDX       = 7'h4C;   // last cell, nearest tdo

   // instruction codes
   localparam logic [3:0] IR_EXTEST  = 4'h0;
   localparam logic [3:0] IR_SAMPLE  = 4'h3;
   localparam logic [3:0] IR_CLAMP   = 4'h5;
   localparam logic [3:0] IR_HIGHZ   = 4'h7;
   localparam logic [3:0] IR_CLAMPZ  = 4'h9;
   localparam logic [3:0] IR_INTEST  = 4'hC;
   localparam logic [3:0] IR_BYPASS  = 4'hF;
   localparam logic [3:0] IR_CAPTURE = 4'h1;   // pattern loaded in capture-ir

   // register map, byte addresses
   localparam logic [3:0]  OFF_CTRL   = 4'h0;
   localparam logic [3:0]  OFF_STATUS = 4'h4;
   localparam int          CTRL_PARK  = 0;
   localparam logic        CTRL_RST   = 1'h0;
   localparam logic [31:0] UNMAPPED   = 32'h0000_0000;

   typedef enum logic [3:0] {
      TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR,
      TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
      TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
   } bso_tap_e;

   // values sampled into the chain at capture-dr
   typedef struct packed {
      logic [DATA_W-1:0] core_data;
      logic              core_dis;
      logic              core_hs_b;
      logic              core_hs_a;
      logic [DATA_W-1:0] pad_data;
      logic [MISC_W-1:0] pad_misc;
   } bso_cap_s;

   // test-side state shown to software
   typedef struct packed {
      logic              tdo_active;
      logic              hs_cell;
      logic              data_cell;
      logic [IR_W-1:0]   instr;
   } bso_stat_s;

   // chain index of the input cell of data lane k
   function automatic logic [6:0] din_idx(input int lane);
      din_idx = (lane < SPLIT_LN) ? 7'(2 * lane) : 7'(2 * lane + 1);
   endfunction : din_idx

   // chain index of the output cell of data lane k
   function automatic logic [6:0] dout_idx(input int lane);
      dout_idx = 7'(din_idx(lane) + 7'h01);
   endfunction : dout_idx

endpackage : bso_pkg

/* design/bso_scan_oe.sv */
// bso_scan_oe: test access port, 77-cell boundary chain with its two
// active-low output-enable cells, pin muxing and an avalon status port.
// assumes: tck from an outside test controller, core signals on ref_clk,
// pad inputs asynchronous; the bench resolves the three-state pins.
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
module bso_scan_oe (
   input  wire logic                      ref_clk,
   input  wire logic                      reset,
   input  wire logic                      clk_en,
   input  wire logic [3:0]                avs_address,
   input  wire logic                      avs_read,
   input  wire logic                      avs_write,
   input  wire logic [31:0]               avs_writedata,
   output logic      [31:0]               avs_readdata,
   output logic                           avs_waitrequest,
   input  wire logic                      tck,
   input  wire logic                      trst_n,
   input  wire logic                      tms,
   input  wire logic                      tdi,
   output logic                           tdo_o,
   output logic                           tdo_oe,
   input  wire logic [bso_pkg::DATA_W-1:0] core_data_out,
   input  wire logic                      core_data_drive_disable,
   input  wire logic                      core_hs_a,
   input  wire logic                      core_hs_b,
   output logic      [bso_pkg::DATA_W-1:0] core_data_in,
   output logic      [bso_pkg::MISC_W-1:0] core_misc_in,
   input  wire logic [bso_pkg::DATA_W-1:0] coproc_data_bus_i,
   output logic      [bso_pkg::DATA_W-1:0] coproc_data_bus_o,
   output logic                           coproc_data_bus_oe,
   input  wire logic [bso_pkg::MISC_W-1:0] pad_misc_in,
   output logic                           handshake_a_output,
   output logic                           handshake_b_output,
   output logic                           handshake_oe
);

   bso_pkg::bso_tap_e                 state_q;
   bso_pkg::bso_tap_e                 state_d;
   logic [bso_pkg::IR_W-1:0]          ir_sh_q;
   logic [bso_pkg::IR_W-1:0]          ir_q;
   logic [bso_pkg::BSR_LEN-1:0]       bsr_q;
   logic [bso_pkg::BSR_LEN-1:0]       bsu_q;
   logic [bso_pkg::BSR_LEN-1:0]       cap_vec;
   logic                              bypass_q;
   logic                              tdo_q;
   logic                              tdo_oe_q;
   bso_pkg::bso_cap_s                 cap_raw;
   bso_pkg::bso_cap_s                 cap_m_q;
   bso_pkg::bso_cap_s                 cap_q;
   logic                              sel_bsr;
   logic                              pin_test;
   logic                              all_float;
   logic                              core_test;
   bso_pkg::bso_stat_s                stat_tck;
   bso_pkg::bso_stat_s                stat_m_q;
   bso_pkg::bso_stat_s                stat_q;
   logic                              park_q;
   logic                              ack_q;
   logic [31:0]                       rdata_q;

   // ---------------- test clock domain ----------------

   // instruction decode
   assign sel_bsr   = (ir_q == bso_pkg::IR_SAMPLE) || (ir_q == bso_pkg::IR_EXTEST) ||
                      (ir_q == bso_pkg::IR_INTEST);
   assign pin_test  = (ir_q == bso_pkg::IR_EXTEST) || (ir_q == bso_pkg::IR_CLAMP) ||
                      (ir_q == bso_pkg::IR_INTEST);
   assign all_float = (ir_q == bso_pkg::IR_HIGHZ) || (ir_q == bso_pkg::IR_CLAMPZ);
   assign core_test = (ir_q == bso_pkg::IR_INTEST);

   // tap state transitions on tms
   always_comb begin
      case (state_q)
         bso_pkg::TAP_TLR:    state_d = tms ? bso_pkg::TAP_TLR    : bso_pkg::TAP_RTI;
         bso_pkg::TAP_RTI:    state_d = tms ? bso_pkg::TAP_SEL_DR : bso_pkg::TAP_RTI;
         bso_pkg::TAP_SEL_DR: state_d = tms ? bso_pkg::TAP_SEL_IR : bso_pkg::TAP_CAP_DR;
         bso_pkg::TAP_CAP_DR: state_d = tms ? bso_pkg::TAP_EX1_DR : bso_pkg::TAP_SH_DR;
         bso_pkg::TAP_SH_DR:  state_d = tms ? bso_pkg::TAP_EX1_DR : bso_pkg::TAP_SH_DR;
         bso_pkg::TAP_EX1_DR: state_d = tms ? bso_pkg::TAP_UPD_DR : bso_pkg::TAP_PAU_DR;
         bso_pkg::TAP_PAU_DR: state_d = tms ? bso_pkg::TAP_EX2_DR : bso_pkg::TAP_PAU_DR;
         bso_pkg::TAP_EX2_DR: state_d = tms ? bso_pkg::TAP_UPD_DR : bso_pkg::TAP_SH_DR;
         bso_pkg::TAP_UPD_DR: state_d = tms ? bso_pkg::TAP_SEL_DR : bso_pkg::TAP_RTI;
         bso_pkg::TAP_SEL_IR: state_d = tms ? bso_pkg::TAP_TLR    : bso_pkg::TAP_CAP_IR;
         bso_pkg::TAP_CAP_IR: state_d = tms ? bso_pkg::TAP_EX1_IR : bso_pkg::TAP_SH_IR;
         bso_pkg::TAP_SH_IR:  state_d = tms ? bso_pkg::TAP_EX1_IR : bso_pkg::TAP_SH_IR;
         bso_pkg::TAP_EX1_IR: state_d = tms ? bso_pkg::TAP_UPD_IR : bso_pkg::TAP_PAU_IR;
         bso_pkg::TAP_PAU_IR: state_d = tms ? bso_pkg::TAP_EX2_IR : bso_pkg::TAP_PAU_IR;
         bso_pkg::TAP_EX2_IR: state_d = tms ? bso_pkg::TAP_UPD_IR : bso_pkg::TAP_SH_IR;
         bso_pkg::TAP_UPD_IR: state_d = tms ? bso_pkg::TAP_SEL_DR : bso_pkg::TAP_RTI;
         default:             state_d = bso_pkg::TAP_TLR;
      endcase
   end

   // tap state; trst_n low parks it in reset, tms high keeps it there
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         state_q <= bso_pkg::TAP_TLR;
      end else begin
         state_q <= state_d;
      end
   end

   // two-flop capture of core and pad signals into the test clock
   assign cap_raw = '{core_data: core_data_out, core_dis: core_data_drive_disable,
                      core_hs_b: core_hs_b, core_hs_a: core_hs_a,
                      pad_data: coproc_data_bus_i, pad_misc: pad_misc_in};
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         cap_m_q <= '0;
         cap_q   <= '0;
      end else begin
         cap_m_q <= cap_raw;
         cap_q   <= cap_m_q;
      end
   end

   // parallel capture vector in chain order
   always_comb begin
      cap_vec = '0;
      for (int k = 0; k < bso_pkg::DATA_W; k++) begin
         cap_vec[bso_pkg::din_idx(k)]  = cap_q.pad_data[k];
         cap_vec[bso_pkg::dout_idx(k)] = cap_q.core_data[k];
      end
      cap_vec[bso_pkg::NEN_DATA_IDX] = cap_q.core_dis;
      cap_vec[bso_pkg::NEN_HS_IDX]   = 1'h0;
      cap_vec[bso_pkg::HS_B_IDX]     = cap_q.core_hs_b;
      cap_vec[bso_pkg::HS_A_IDX]     = cap_q.core_hs_a;
      for (int m = 0; m < bso_pkg::MISC_W; m++) begin
         cap_vec[7'(bso_pkg::MISC_BASE_IDX + 7'(m))] = cap_q.pad_misc[m];
      end
   end

   // boundary shift register: capture and shift on the rising edge
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         bsr_q <= '0;
      end else if (sel_bsr && state_q == bso_pkg::TAP_CAP_DR) begin
         bsr_q <= cap_vec;
      end else if (sel_bsr && state_q == bso_pkg::TAP_SH_DR) begin
         bsr_q <= {bsr_q[bso_pkg::BSR_LEN-2:0], tdi};
      end
   end

   // one-bit bypass path, also used under highz
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         bypass_q <= 1'h0;
      end else if (state_q == bso_pkg::TAP_CAP_DR) begin
         bypass_q <= 1'h0;
      end else if (state_q == bso_pkg::TAP_SH_DR) begin
         bypass_q <= tdi;
      end
   end

   // instruction shift register
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         ir_sh_q <= bso_pkg::IR_CAPTURE;
      end else if (state_q == bso_pkg::TAP_CAP_IR) begin
         ir_sh_q <= bso_pkg::IR_CAPTURE;
      end else if (state_q == bso_pkg::TAP_SH_IR) begin
         ir_sh_q <= {tdi, ir_sh_q[bso_pkg::IR_W-1:1]};
      end
   end

   // current instruction changes on the falling edge in update-ir
   always_ff @(negedge tck or negedge trst_n) begin
      if (!trst_n) begin
         ir_q <= bso_pkg::IR_BYPASS;
      end else if (state_q == bso_pkg::TAP_TLR) begin
         ir_q <= bso_pkg::IR_BYPASS;
      end else if (state_q == bso_pkg::TAP_UPD_IR) begin
         ir_q <= ir_sh_q;
      end
   end

   // update latch: held indefinitely while tck stands still
   always_ff @(negedge tck or negedge trst_n) begin
      if (!trst_n) begin
         bsu_q <= '0;
      end else if (sel_bsr && state_q == bso_pkg::TAP_UPD_DR) begin
         bsu_q <= bsr_q;
      end
   end

   // serial output, enabled only inside shift states
   always_ff @(negedge tck or negedge trst_n) begin
      if (!trst_n) begin
         tdo_q    <= 1'h0;
         tdo_oe_q <= 1'h0;
      end else begin
         tdo_oe_q <= (state_q == bso_pkg::TAP_SH_DR) || (state_q == bso_pkg::TAP_SH_IR);
         if (state_q == bso_pkg::TAP_SH_IR) begin
            tdo_q <= ir_sh_q[0];
         end else if (sel_bsr) begin
            tdo_q <= bsr_q[bso_pkg::TDO_IDX];
         end else begin
            tdo_q <= bypass_q;
         end
      end
   end
   assign tdo_o  = tdo_q;
   assign tdo_oe = tdo_oe_q;

   // pin drivers: chain cells in test modes, core otherwise
   always_comb begin
      for (int k = 0; k < bso_pkg::DATA_W; k++) begin
         coproc_data_bus_o[k] = pin_test ? bsu_q[bso_pkg::dout_idx(k)] : core_data_out[k];
      end
      handshake_a_output = pin_test ? bsu_q[bso_pkg::HS_A_IDX] : core_hs_a;
      handshake_b_output = pin_test ? bsu_q[bso_pkg::HS_B_IDX] : core_hs_b;
      if (all_float || park_q) begin
         coproc_data_bus_oe = 1'h0;
         handshake_oe       = 1'h0;
      end else if (pin_test) begin
         coproc_data_bus_oe = ~bsu_q[bso_pkg::NEN_DATA_IDX];
         handshake_oe       = ~bsu_q[bso_pkg::NEN_HS_IDX];
      end else begin
         coproc_data_bus_oe = ~core_data_drive_disable;
         handshake_oe       = 1'h1;
      end
   end

   // core inputs: stimulus from the chain under intest, pads otherwise
   always_comb begin
      for (int k = 0; k < bso_pkg::DATA_W; k++) begin
         core_data_in[k] = core_test ? bsu_q[bso_pkg::din_idx(k)] : coproc_data_bus_i[k];
      end
      for (int m = 0; m < bso_pkg::MISC_W; m++) begin
         core_misc_in[m] = core_test ? bsu_q[7'(bso_pkg::MISC_BASE_IDX + 7'(m))] : pad_misc_in[m];
      end
   end

   // ---------------- register clock domain ----------------

   // test-side status brought over by two flops per bit
   assign stat_tck = '{tdo_active: tdo_oe_q, hs_cell: bsu_q[bso_pkg::NEN_HS_IDX],
                       data_cell: bsu_q[bso_pkg::NEN_DATA_IDX], instr: ir_q};
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         stat_m_q <= '0;
         stat_q   <= '0;
      end else if (clk_en) begin
         stat_m_q <= stat_tck;
         stat_q   <= stat_m_q;
      end
   end

   // one wait cycle on every access while clk_en is high; waitrequest holds while clk_en is low
   assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ack_q <= 1'h0;
      end else if (clk_en) begin
         ack_q <= (avs_read || avs_write) && !ack_q;
      end
   end

   // read data latched while waitrequest is high
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rdata_q <= bso_pkg::UNMAPPED;
      end else if (clk_en && avs_read && !ack_q) begin
         case (avs_address)
            bso_pkg::OFF_CTRL:   rdata_q <= {31'h0, park_q};
            bso_pkg::OFF_STATUS: rdata_q <= {25'h0, stat_q};
            default:             rdata_q <= bso_pkg::UNMAPPED;
         endcase
      end
   end
   assign avs_readdata = rdata_q;

   // park bit forces the data and handshake pin drivers off; tdo is not affected
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         park_q <= bso_pkg::CTRL_RST;
      end else if (clk_en && avs_write && ack_q && avs_address == bso_pkg::OFF_CTRL) begin
         park_q <= avs_writedata[bso_pkg::CTRL_PARK];
      end
   end

   // ---------------- checks ----------------

   property p_data_cell_gate;
      @(posedge tck) disable iff (!trst_n)
      (pin_test && !park_q && bsu_q[bso_pkg::NEN_DATA_IDX]) |-> !coproc_data_bus_oe;
   endproperty
   a_data_cell_gate: assert property (p_data_cell_gate) else $error("data enable cell ignored");

   property p_hs_cell_gate;
      @(posedge tck) disable iff (!trst_n)
      (pin_test && !park_q && !all_float) |-> (handshake_oe == !bsu_q[bso_pkg::NEN_HS_IDX]);
   endproperty
   a_hs_cell_gate: assert property (p_hs_cell_gate) else $error("handshake enable wrong");

   property p_cap_core_dis;
      @(posedge tck) disable iff (!trst_n)
      (sel_bsr && state_q == bso_pkg::TAP_CAP_DR) |=>
         (bsr_q[bso_pkg::NEN_DATA_IDX] == $past(cap_q.core_dis));
   endproperty
   a_cap_core_dis: assert property (p_cap_core_dis) else $error("core disable not captured");

   property p_cap_hs_zero;
      @(posedge tck) disable iff (!trst_n)
      (sel_bsr && state_q == bso_pkg::TAP_CAP_DR) |=> !bsr_q[bso_pkg::NEN_HS_IDX];
   endproperty
   a_cap_hs_zero: assert property (p_cap_hs_zero) else $error("handshake cell not zero");

   property p_intest_apply;
      @(negedge tck) disable iff (!trst_n)
      (core_test && state_q == bso_pkg::TAP_UPD_DR) |=> (core_data_in[0] == $past(bsr_q[0]));
   endproperty
   a_intest_apply: assert property (p_intest_apply) else $error("stimulus not applied");

   property p_tdo_enable;
      @(negedge tck) disable iff (!trst_n)
      (state_q == bso_pkg::TAP_SH_DR || state_q == bso_pkg::TAP_SH_IR) |=> tdo_oe_q;
   endproperty
   a_tdo_enable: assert property (p_tdo_enable) else $error("tdo not driven in shift");

   property p_tdo_release;
      @(negedge tck) disable iff (!trst_n)
      (state_q == bso_pkg::TAP_EX1_DR || state_q == bso_pkg::TAP_EX1_IR) |=> !tdo_oe_q;
   endproperty
   a_tdo_release: assert property (p_tdo_release) else $error("tdo left driven");

   property p_cap_pad;
      @(posedge tck) disable iff (!trst_n)
      (sel_bsr && state_q == bso_pkg::TAP_CAP_DR) |=> (bsr_q[0] == $past(cap_q.pad_data[0]));
   endproperty
   a_cap_pad: assert property (p_cap_pad) else $error("pad value not captured");

   property p_shift_in;
      @(posedge tck) disable iff (!trst_n)
      (sel_bsr && state_q == bso_pkg::TAP_SH_DR) |=> (bsr_q[0] == $past(tdi));
   endproperty
   a_shift_in: assert property (p_shift_in) else $error("tdi not shifted in");

   property p_highz;
      @(posedge tck) disable iff (!trst_n)
      (ir_q == bso_pkg::IR_HIGHZ) |-> (!coproc_data_bus_oe && !handshake_oe && !sel_bsr);
   endproperty
   a_highz: assert property (p_highz) else $error("highz left a driver on");

   property p_bus_answer;
      @(posedge ref_clk) disable iff (reset)
      (clk_en && avs_waitrequest) |=> !avs_waitrequest;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

endmodule : bso_scan_oe

/* verif/bso_scan_oe_test.sv */
// bso_scan_oe_test: self-checking bench for the scan output-enable block.
// assumes: bso_tap_ctl drives the tap; avalon master written here.
module bso_scan_oe_test;
   timeunit 1ns;
   timeprecision 100ps;

   localparam logic [76:0] BYP_PAT = 77'h1_5A5A_C3C3_0F0F_9696_E1E;
   logic        ref_clk = 1'b0, reset = 1'b1, clk_en = 1'b1;
   logic [3:0]  avs_address = '0;
   logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [31:0] avs_writedata = '0, avs_readdata, rd;
   logic        tck, trst_n, tms, tdi, tdo_o, tdo_oe;
   logic [31:0] core_data_out = 32'h3C69_E1B4, core_data_in, coproc_data_bus_o;
   logic [31:0] coproc_data_bus_i = 32'hA5C3_0F96;
   logic        core_data_drive_disable = 1'b0, core_hs_a = 1'b1, core_hs_b = 1'b0;
   logic        coproc_data_bus_oe, handshake_a_output, handshake_b_output, handshake_oe;
   logic [8:0]  core_misc_in, pad_misc_in = 9'h15A;
   logic [76:0] dout;
   logic [1:0]  tdo_seen;
   int          n_fail = 0, comparisons = 0;

   bso_scan_oe dut (.ref_clk, .reset, .clk_en, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest, .tck, .trst_n, .tms, .tdi, .tdo_o,
      .tdo_oe, .core_data_out, .core_data_drive_disable, .core_hs_a, .core_hs_b,
      .core_data_in, .core_misc_in, .coproc_data_bus_i, .coproc_data_bus_o,
      .coproc_data_bus_oe, .pad_misc_in, .handshake_a_output, .handshake_b_output,
      .handshake_oe);
   bso_tap_ctl ctl (.tck, .trst_n, .tms, .tdi, .tdo_o, .tdo_oe);

   // register clock, 25 MHz
   always #20 ref_clk = ~ref_clk;

   // tdo must hold across the rising tck edge
   always @(posedge tck) begin
      tdo_seen = {tdo_o, tdo_oe};
      #2;
      chk({tdo_o, tdo_oe}, tdo_seen, "tdo moved on rise");
   end

   task automatic chk(input logic [76:0] seen, input logic [76:0] exp, input string m);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk

   // chain image: lane inputs, lane outputs, {hs_a, hs_b, hs_en, data_en}, misc
   function automatic logic [76:0] mk(input logic [31:0] iv, input logic [31:0] ov,
                                      input logic [3:0] c, input logic [8:0] m);
      logic [76:0] r;
      int          k;
      r = '0;
      for (k = 0; k < 32; k++) begin
         r[k < 18 ? 2 * k : 2 * k + 1] = iv[k];
         r[k < 18 ? 2 * k + 1 : 2 * k + 2] = ov[k];
      end
      r[36] = c[0];
      r[76:65] = {m, c[3:1]};
      return r;
   endfunction : mk

   // lane input (o=0) or output (o=1) cells of a chain image
   function automatic logic [31:0] ln(input logic [76:0] v, input int o);
      int k;
      for (k = 0; k < 32; k++) ln[k] = v[(k < 18 ? 2 * k : 2 * k + 1) + o];
   endfunction : ln

   // one avalon access; waitrequest and read data taken at the same rising edge
   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      logic ws;
      @(posedge ref_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do begin
         @(posedge ref_clk);
         ws = avs_waitrequest;
         q = avs_readdata;
      end while (ws !== 1'b0);
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      chk(ws, 1'b0, "bus hang");
   endtask : av

   task automatic st(output logic [31:0] q);
      repeat (4) @(posedge ref_clk);
      av(1'b0, bso_pkg::OFF_STATUS, '0, q);
   endtask : st

   task automatic sc(input logic ir, input int n, input logic [76:0] din,
                     output logic [76:0] q);
      ctl.scan(ir, n, din, q);
      chk(tdo_oe, 1'b0, "tdo driven in idle");
   endtask : sc

   task automatic t_reset();
      ctl.tap_reset();
      sc(1'b1, 4, 77'(bso_pkg::IR_BYPASS), dout);
      chk(dout[3:0], bso_pkg::IR_CAPTURE, "ir capture");
      chk({coproc_data_bus_oe, handshake_oe, coproc_data_bus_o, handshake_a_output,
           handshake_b_output}, {2'b11, core_data_out, core_hs_a, core_hs_b}, "pins");
      @(posedge ref_clk);
      core_data_drive_disable <= 1'b1;
      @(posedge ref_clk);
      chk(coproc_data_bus_oe, 1'b0, "core disable");
      st(rd);
      chk(rd[6:0], {3'b000, bso_pkg::IR_BYPASS}, "status after reset");
      $display("t_reset done");
   endtask : t_reset

   task automatic t_sample();
      sc(1'b1, 4, 77'(bso_pkg::IR_SAMPLE), dout);
      sc(1'b0, 77, mk('0, 32'h0F0F_55AA, 4'hC, '0), dout);
      chk(ln(dout, 0), coproc_data_bus_i, "pad capture");
      chk(ln(dout, 1), core_data_out, "core capture");
      chk(dout[36], 1'b1, "data enable capture");
      chk(dout[67:65], {core_hs_a, core_hs_b, 1'b0}, "handshake capture");
      chk(dout[76:68], pad_misc_in, "misc capture");
      $display("t_sample done");
   endtask : t_sample

   task automatic t_extest();
      int c;
      sc(1'b1, 4, 77'(bso_pkg::IR_EXTEST), dout);
      for (c = 3; c >= 0; c--) begin
         sc(1'b0, 77, mk('0, 32'h0F0F_55AA, {2'b10, 2'(c)}, '0), dout);
         chk(coproc_data_bus_oe, !c[0], "data enable cell");
         chk(handshake_oe, !c[1], "handshake enable cell");
      end
      chk({coproc_data_bus_o, handshake_a_output, handshake_b_output},
          {32'h0F0F_55AA, 2'b10}, "extest pins");
      $display("t_extest done");
   endtask : t_extest

   task automatic t_regs();
      @(posedge ref_clk);
      clk_en <= 1'b0;
      fork
         av(1'b1, bso_pkg::OFF_CTRL, 32'h1, rd);
         begin
            repeat (5) @(posedge ref_clk);
            chk({avs_waitrequest, coproc_data_bus_oe}, 2'b11, "clock enable freeze");
            clk_en <= 1'b1;
         end
      join
      @(posedge ref_clk);
      chk({coproc_data_bus_oe, handshake_oe}, 2'b00, "park");
      av(1'b0, bso_pkg::OFF_CTRL, '0, rd);
      chk(rd, 32'h1, "ctrl readback");
      av(1'b1, bso_pkg::OFF_STATUS, 32'hFFFF_FFFF, rd);
      st(rd);
      chk(rd[6:0], {3'b000, bso_pkg::IR_EXTEST}, "status");
      av(1'b0, 4'h8, '0, rd);
      chk(rd, bso_pkg::UNMAPPED, "unmapped read");
      av(1'b1, bso_pkg::OFF_CTRL, '0, rd);
      @(posedge ref_clk);
      chk({coproc_data_bus_oe, handshake_oe}, 2'b11, "unpark");
      $display("t_regs done");
   endtask : t_regs

   task automatic t_highz();
      sc(1'b1, 4, 77'(bso_pkg::IR_HIGHZ), dout);
      chk({coproc_data_bus_oe, handshake_oe}, 2'b00, "highz pins");
      sc(1'b0, 77, BYP_PAT, dout);
      chk(dout, {1'b0, BYP_PAT[76:1]}, "bypass path");
      $display("t_highz done");
   endtask : t_highz

   task automatic t_intest();
      sc(1'b1, 4, 77'(bso_pkg::IR_INTEST), dout);
      sc(1'b0, 77, mk(32'h1234_5678, '0, 4'hF, 9'h0C3), dout);
      chk({core_data_in, core_misc_in}, {32'h1234_5678, 9'h0C3}, "stimulus");
      chk({coproc_data_bus_oe, handshake_oe}, 2'b00, "guard floats");
      ctl.halt(1'b1, 3000);
      ctl.halt(1'b0, 3000);
      st(rd);
      chk(rd[5:0], {2'b11, bso_pkg::IR_INTEST}, "state after halt");
      chk(core_data_in, 32'h1234_5678, "stimulus held");
      core_data_out <= 32'h8765_4321;
      core_data_drive_disable <= 1'b0;
      sc(1'b0, 77, '1, dout);
      chk(ln(dout, 1), 32'h8765_4321, "response capture");
      chk({dout[65], dout[36]}, 2'b00, "enable captures");
      $display("t_intest done");
   endtask : t_intest

   task automatic give_verdict();
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict

   // main sequence
   initial begin
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      t_reset();
      t_sample();
      t_extest();
      t_regs();
      t_highz();
      t_intest();
      give_verdict();
   end

   // watchdog, well past the expected run of about 43 us
   initial begin
      #400000;
      n_fail++;
      give_verdict();
   end
endmodule : bso_scan_oe_test

/* verif/bso_tap_ctl.sv */
// bso_tap_ctl: behavioural outside test controller on the tap pins.
// assumes: tck of 48 ns that stands low between frames; tdo pulled up.
module bso_tap_ctl (
   output logic      tck,
   output logic      trst_n,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo_o,
   input  wire logic tdo_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   // pins start in reset with mode-select high
   initial begin
      tck = 1'b0;
      trst_n = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // one tck cycle; tdo read late in the low phase
   task automatic step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #24;
      o = tdo_oe ? tdo_o : 1'b1;   // floating tdo reads as the pull-up
      tck = 1'b1;
      #24;
      tck = 1'b0;
   endtask : step

   // async reset, then park in run-test-idle
   task automatic tap_reset();
      logic o;
      tms = 1'b1;
      trst_n = 1'b0;
      #100;
      trst_n = 1'b1;
      #48;
      step(1'b0, 1'b0, o);
   endtask : tap_reset

   // idle to shift and back; ir is lsb first, dr bit 76 enters first
   task automatic scan(input logic ir, input int n, input logic [76:0] din,
                       output logic [76:0] dout);
      logic o;
      int   k;
      int   j;
      dout = '0;
      step(1'b1, 1'b0, o);
      if (ir) step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
      step(1'b0, 1'b0, o);
      for (k = 0; k < n; k++) begin
         j = ir ? k : 76 - k;
         step(k == n - 1, din[j], o);
         dout[j] = o;
      end
      step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
   endtask : scan

   // stop tck at a level for a while; no minimum rate
   task automatic halt(input logic lvl, input int ns);
      #24;   // keep a full low phase before any rise
      tck = lvl;
      #(ns);
      tck = 1'b0;
   endtask : halt
endmodule : bso_tap_ctl
